// ### smlp_port.sv
// latency sequencer for one PHY port on a serial MII link, 100 Mb modes
// assumes line-side delimiter strobes and transmit enable are synchronous
// to clk_sys, and that the MAC samples every receive segment
//
// Functional notes
// - carrier sense rises within 29 BT (TX) or 26 BT (FX) after /J/
// - carrier sense falls within 30 BT (TX) or 27 BT (FX) after /T/
// - TX mode: /J/ starts on line within 18 BT of sampled TxEN
// - latencies counted in line bit times: 10 ns at 100 Mb, 100 ns at 10
// - the limits hold with fill select 00, a 32-bit initial fill
`timescale 1ns/1ns
`default_nettype none
`include "smlp_consts.svh"

module smlp_port
  import smlp_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic       clk_sys,             // 20 MHz system clock
  input  wire logic       rst_n,               // async reset, active low
  input  wire logic       media_fx,            // 1: 100BASE-FX, 0: TX
  input  wire logic [1:0] initial_fill_select, // elasticity fill code
  input  wire logic       rx_ssd_det,          // /J/ received, pulse
  input  wire logic       rx_esd_det,          // /T/ received, pulse
  input  wire logic       tx_en,               // TxEN from serial tx
  output logic            crs,                 // carrier sense to MAC
  output logic            line_tx_ssd,         // start /J/ on line, pulse
  output logic            line_tx_esd,         // start /T/ on line, pulse
  output logic            line_tx_active,      // line transmit in frame
  output logic            fill_default,        // fill select is 00
  output logic [7:0]      fill_bits            // current initial fill
);

  // ************************************************************
  // latencies as cycle counts
  // ************************************************************
  // longest times round down, but never below one cycle
  function automatic int to_cyc(input int bt, input int bt_ns);
    int c;
    c = (bt * bt_ns) / `SMLP_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : to_cyc

  localparam int CRS_ON_TX_CYC  =
    to_cyc(`SMLP_CRS_ON_TX_BT, `SMLP_BT_NS_100);
  localparam int CRS_ON_FX_CYC  =
    to_cyc(`SMLP_CRS_ON_FX_BT, `SMLP_BT_NS_100);
  localparam int CRS_OFF_TX_CYC =
    to_cyc(`SMLP_CRS_OFF_TX_BT, `SMLP_BT_NS_100);
  localparam int CRS_OFF_FX_CYC =
    to_cyc(`SMLP_CRS_OFF_FX_BT, `SMLP_BT_NS_100);
  localparam int TX_SSD_CYC     =
    to_cyc(`SMLP_TX_SSD_BT, `SMLP_BT_NS_100);

  // extra fill beyond the default adds whole cycles only, rounded down
  localparam int FILL_X1_CYC =
    ((`SMLP_FILL_BITS_1 - `SMLP_FILL_BITS_0) * `SMLP_BT_NS_100)
    / `SMLP_CLK_NS;
  localparam int FILL_X2_CYC =
    ((`SMLP_FILL_BITS_2 - `SMLP_FILL_BITS_0) * `SMLP_BT_NS_100)
    / `SMLP_CLK_NS;
  localparam int FILL_X3_CYC =
    ((`SMLP_FILL_BITS_3 - `SMLP_FILL_BITS_0) * `SMLP_BT_NS_100)
    / `SMLP_CLK_NS;

  // ************************************************************
  // declarations
  // ************************************************************
  smlp_media_t           media;
  smlp_crs_state_t       crs_state_q;
  logic [CNT_W-1:0]      fill_extra;
  logic [CNT_W-1:0]      crs_on_n;
  logic [CNT_W-1:0]      crs_off_n;
  logic [CNT_W-1:0]      ch_n     [`SMLP_NUM_CH];
  logic                  ch_start [`SMLP_NUM_CH];
  logic                  ch_fire  [`SMLP_NUM_CH];
  logic                  ch_busy  [`SMLP_NUM_CH];
  logic                  tx_en_q;
  logic                  tx_rise;
  logic                  tx_fall;
  logic                  tx_act_q;
  logic [7:0]            fill_bits_q;
  logic                  fill_def_q;

  assign media = media_fx ? SMLP_MEDIA_FX : SMLP_MEDIA_TX;

  // ************************************************************
  // elasticity fill
  // ************************************************************
  // the latency figures are only guaranteed at the default fill;
  // larger fills push every path out by the extra buffered bits
  always_comb begin
    case (initial_fill_select)
      2'h0:    fill_extra = '0;
      2'h1:    fill_extra = CNT_W'(FILL_X1_CYC);
      2'h2:    fill_extra = CNT_W'(FILL_X2_CYC);
      2'h3:    fill_extra = CNT_W'(FILL_X3_CYC);
      default: fill_extra = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fill_bits_q <= 8'(`SMLP_FILL_BITS_0);
      fill_def_q  <= 1'b1;
    end else begin
      case (initial_fill_select)
        2'h0:    fill_bits_q <= 8'(`SMLP_FILL_BITS_0);
        2'h1:    fill_bits_q <= 8'(`SMLP_FILL_BITS_1);
        2'h2:    fill_bits_q <= 8'(`SMLP_FILL_BITS_2);
        2'h3:    fill_bits_q <= 8'(`SMLP_FILL_BITS_3);
        default: fill_bits_q <= 8'(`SMLP_FILL_BITS_0);
      endcase
      fill_def_q <= (initial_fill_select == `SMLP_FILL_SEL_DEF);
    end
  end

  // ************************************************************
  // per-media receive latencies
  // ************************************************************
  always_comb begin
    case (media)
      SMLP_MEDIA_FX: begin
        crs_on_n  = CNT_W'(CRS_ON_FX_CYC) + fill_extra;
        crs_off_n = CNT_W'(CRS_OFF_FX_CYC) + fill_extra;
      end
      SMLP_MEDIA_TX: begin
        crs_on_n  = CNT_W'(CRS_ON_TX_CYC) + fill_extra;
        crs_off_n = CNT_W'(CRS_OFF_TX_CYC) + fill_extra;
      end
      default: begin
        crs_on_n  = CNT_W'(CRS_ON_TX_CYC) + fill_extra;
        crs_off_n = CNT_W'(CRS_OFF_TX_CYC) + fill_extra;
      end
    endcase
  end

  // ************************************************************
  // transmit enable edges
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_en_q <= 1'b0;
    end else begin
      tx_en_q <= tx_en;
    end
  end

  assign tx_rise = tx_en && !tx_en_q;
  assign tx_fall = !tx_en && tx_en_q;

  // ************************************************************
  // delay channels
  // ************************************************************
  // FX transmit uses the TX figure too; it is the tighter of the two
  // carrier state flop adds the last cycle of each receive path
  assign ch_n[`SMLP_CH_CRS_ON]     = crs_on_n - CNT_W'(1);
  assign ch_n[`SMLP_CH_CRS_OFF]    = crs_off_n - CNT_W'(1);
  assign ch_n[`SMLP_CH_TX_SSD]     = CNT_W'(TX_SSD_CYC) + fill_extra;
  assign ch_n[`SMLP_CH_TX_ESD]     = CNT_W'(TX_SSD_CYC) + fill_extra;
  assign ch_start[`SMLP_CH_CRS_ON]  = rx_ssd_det;
  assign ch_start[`SMLP_CH_CRS_OFF] = rx_esd_det;
  assign ch_start[`SMLP_CH_TX_SSD]  = tx_rise;
  assign ch_start[`SMLP_CH_TX_ESD]  = tx_fall;

  for (genvar i = 0; i < `SMLP_NUM_CH; i++) begin : g_ch
    smlp_delay #(
      .CNT_W (CNT_W)
    ) u_delay (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .start   (ch_start[i]),
      .n       (ch_n[i]),
      .fire    (ch_fire[i]),
      .busy    (ch_busy[i])
    );
  end

  // ************************************************************
  // carrier sense
  // ************************************************************
  // a new /J/ maturing in the same cycle as the old /T/ keeps carrier
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      crs_state_q <= SMLP_CRS_IDLE;
    end else begin
      case (crs_state_q)
        SMLP_CRS_IDLE: begin
          if (ch_fire[`SMLP_CH_CRS_ON]) begin
            crs_state_q <= SMLP_CRS_ACTIVE;
          end
        end
        SMLP_CRS_ACTIVE: begin
          if (ch_fire[`SMLP_CH_CRS_OFF] && !ch_fire[`SMLP_CH_CRS_ON])
          begin
            crs_state_q <= SMLP_CRS_IDLE;
          end
        end
        default: crs_state_q <= SMLP_CRS_IDLE;
      endcase
    end
  end

  // held as a level every cycle so each receive segment carries it
  assign crs = (crs_state_q == SMLP_CRS_ACTIVE);

  // ************************************************************
  // line transmit
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_act_q <= 1'b0;
    end else if (ch_fire[`SMLP_CH_TX_SSD]) begin
      tx_act_q <= 1'b1;
    end else if (ch_fire[`SMLP_CH_TX_ESD]) begin
      tx_act_q <= 1'b0;
    end
  end

  assign line_tx_ssd    = ch_fire[`SMLP_CH_TX_SSD];
  assign line_tx_esd    = ch_fire[`SMLP_CH_TX_ESD];
  assign line_tx_active = tx_act_q;
  assign fill_default   = fill_def_q;
  assign fill_bits      = fill_bits_q;

endmodule : smlp_port

`default_nettype wire

// ### smlp_consts.svh
// timing and configuration constants for one SMII port latency block
// assumes a single system clock; all figures in ns or line bit times
`ifndef SMLP_CONSTS_SVH
`define SMLP_CONSTS_SVH

// ************************************************************
// clock and line rate
// ************************************************************
`define SMLP_CLK_NS          50
`define SMLP_BT_NS_100       10
`define SMLP_BT_NS_10        100

// ************************************************************
// longest latencies, in line bit times
// ************************************************************
`define SMLP_CRS_ON_TX_BT    29
`define SMLP_CRS_ON_FX_BT    26
`define SMLP_CRS_OFF_TX_BT   30
`define SMLP_CRS_OFF_FX_BT   27
`define SMLP_TX_SSD_BT       18

// ************************************************************
// initial elasticity fill, in bits, per select code
// ************************************************************
`define SMLP_FILL_SEL_DEF    2'h0
`define SMLP_FILL_BITS_0     32
`define SMLP_FILL_BITS_1     48
`define SMLP_FILL_BITS_2     64
`define SMLP_FILL_BITS_3     80

// ************************************************************
// delay channel indices
// ************************************************************
`define SMLP_CH_CRS_ON       0
`define SMLP_CH_CRS_OFF      1
`define SMLP_CH_TX_SSD       2
`define SMLP_CH_TX_ESD       3
`define SMLP_NUM_CH          4

`endif

// ### smlp_pkg.sv
// types shared by the SMII port latency block
// assumes smlp_consts.svh for all numeric figures
package smlp_pkg;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic {
    SMLP_MEDIA_TX,
    SMLP_MEDIA_FX
  } smlp_media_t;

  typedef enum logic [1:0] {
    SMLP_CRS_IDLE,
    SMLP_CRS_ACTIVE
  } smlp_crs_state_t;

endpackage : smlp_pkg

// ### smlp_delay.sv
// one programmable pulse delay: fire rises n cycles after start
// assumes start is a one-cycle pulse synchronous to clk_sys; n >= 1
`timescale 1ns/1ns
`default_nettype none

module smlp_delay #(
  parameter int CNT_W = 8
) (
  input  wire logic             clk_sys, // system clock
  input  wire logic             rst_n,   // async reset, active low
  input  wire logic             start,   // begin a delay
  input  wire logic [CNT_W-1:0] n,       // delay in cycles
  output logic                  fire,    // one-cycle pulse, registered
  output logic                  busy     // delay in progress
);

  logic [CNT_W-1:0] cnt_q;
  logic             fire_q;
  logic             busy_q;

  // ************************************************************
  // countdown; a new start restarts the count
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q  <= n - CNT_W'(1);
      busy_q <= (n > CNT_W'(1));
    end else if (busy_q) begin
      cnt_q  <= cnt_q - CNT_W'(1);
      busy_q <= (cnt_q > CNT_W'(1));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fire_q <= 1'b0;
    end else begin
      fire_q <= (start && n <= CNT_W'(1)) ||
                (!start && busy_q && cnt_q == CNT_W'(1));
    end
  end

  assign fire = fire_q;
  assign busy = busy_q;

endmodule : smlp_delay

`default_nettype wire

// ### smlp_port_chk.sv
// latency assertions for smlp_port, attached by bind
// assumes fill select stays put while a delay is pending
`timescale 1ns/1ns
`default_nettype none
module smlp_port_chk #(
  parameter int CNT_W = 8
) (
  input wire logic       clk_sys,             // clock
  input wire logic       rst_n,               // reset
  input wire logic       media_fx,            // media mode
  input wire logic [1:0] initial_fill_select, // fill code
  input wire logic       rx_ssd_det,          // rx start
  input wire logic       rx_esd_det,          // rx end
  input wire logic       tx_en,               // tx enable
  input wire logic       crs,                 // carrier
  input wire logic       line_tx_ssd,         // tx start
  input wire logic       line_tx_esd,         // tx end
  input wire logic       line_tx_active,      // tx frame
  input wire logic       fill_default,        // code is 00
  input wire logic [7:0] fill_bits            // fill size
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ************************************************************
  // latency bounds, checked only with the default fill; pulse and fill map checks at any fill
  // ************************************************************
  sequence tx_start_s;
    line_tx_ssd ##1 line_tx_active;
  endsequence
  crs_on_a: assert property (rx_ssd_det && fill_default |-> ##[1:5] crs)
    else $error("carrier sense late");
  crs_cause_a: assert property ($rose(crs) && fill_default |->
    $past(rx_ssd_det, 5)) else $error("carrier sense without start");
  crs_off_a: assert property (rx_esd_det && fill_default
    |-> ##[1:6] !crs) else $error("carrier sense held too long");
  crs_off_fx_a: assert property (rx_esd_det && fill_default && media_fx
    |-> ##[1:5] !crs) else $error("fiber carrier held too long");
  tx_start_a: assert property ($rose(tx_en) && fill_default
    |-> ##[1:3] tx_start_s) else $error("line start late");
  ssd_pulse_a: assert property (line_tx_ssd |=> !line_tx_ssd)
    else $error("line start not a pulse");
  fill_map_a: assert property ($past(rst_n) |->
    fill_bits == 8'h20 + {$past(initial_fill_select), 4'h0}
    && fill_default == ($past(initial_fill_select) == 2'h0))
    else $error("fill outputs wrong");
endmodule : smlp_port_chk
bind smlp_port smlp_port_chk #(.CNT_W(CNT_W)) u_smlp_port_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .media_fx(media_fx),
  .initial_fill_select(initial_fill_select), .rx_ssd_det(rx_ssd_det),
  .rx_esd_det(rx_esd_det), .tx_en(tx_en), .crs(crs),
  .line_tx_ssd(line_tx_ssd), .line_tx_esd(line_tx_esd),
  .line_tx_active(line_tx_active), .fill_default(fill_default),
  .fill_bits(fill_bits));
`default_nettype wire

// ### smlp_mac_model.sv
// far-side MAC: sends tx frames, samples carrier every segment
// assumes go is a one-cycle request while no frame is running
`timescale 1ns/1ns
`default_nettype none
module smlp_mac_model (
  input  wire logic       clk_sys, // clock
  input  wire logic       rst_n,   // reset
  input  wire logic       go,      // start a frame
  input  wire logic [7:0] len,     // frame cycles
  input  wire logic       crs,     // carrier sense
  output logic            tx_en,   // tx enable
  output logic [7:0]      frames   // carrier events
);
  logic [7:0] left_q;
  logic       crs_q;
  // requests during a frame are dropped, as a real MAC would
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_en  <= 1'b0;
      left_q <= 8'h00;
    end else if (go && left_q == 8'h00) begin
      tx_en  <= 1'b1;
      left_q <= len;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
      if (left_q == 8'h01) tx_en <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      crs_q  <= 1'b0;
      frames <= 8'h00;
    end else begin
      crs_q <= crs;
      if (crs && !crs_q) frames <= frames + 8'h01;
    end
  end
endmodule : smlp_mac_model
`default_nettype wire

// ### smlp_port_latency_tb.sv
// self-checking bench for smlp_port with the MAC model
// assumes the checker is bound in; 50 ns clock
`timescale 1ns/1ns
`default_nettype none
module smlp_port_latency_tb;
  logic       clk_sys, rst_n, media_fx, rx_ssd_det, rx_esd_det, go;
  logic       tx_en, crs, line_tx_ssd, line_tx_esd, fill_default;
  logic       line_tx_active;
  logic [1:0] sel;
  logic [7:0] fill_bits, len, frames, r;
  int         fail_count, check_count, k;
  smlp_port #(.CNT_W(8)) u_smlp_port (.clk_sys(clk_sys), .rst_n(rst_n),
    .media_fx(media_fx), .initial_fill_select(sel),
    .rx_ssd_det(rx_ssd_det), .rx_esd_det(rx_esd_det), .tx_en(tx_en),
    .crs(crs), .line_tx_ssd(line_tx_ssd), .line_tx_esd(line_tx_esd),
    .line_tx_active(line_tx_active), .fill_default(fill_default),
    .fill_bits(fill_bits));
  smlp_mac_model u_smlp_mac_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .go(go), .len(len), .crs(crs), .tx_en(tx_en), .frames(frames));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  // tx paths carry one extra cycle for the model turning go into tx_en
  function automatic int exp_lat(input int ch, input logic fx,
                                 input logic [1:0] s, input logic [7:0] n);
    int b;
    case (ch)
      0: b = 5;
      1: b = fx ? 5 : 6;
      2: b = 4;
      default: b = int'(n) + 4;
    endcase
    return b + 3 * int'(s);
  endfunction : exp_lat
  task automatic cmp_n(input int exp, input int got);
    check_count++;
    if (exp != got) begin
      fail_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp_n
  task automatic cmp_v(input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (exp !== got) begin
      fail_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp_v
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  // cycles from stimulus edge to the awaited output
  task automatic run(input int ch, output int n);
    n = 0;
    @(posedge clk_sys);
    case (ch)
      0: rx_ssd_det <= 1'b1;
      1: rx_esd_det <= 1'b1;
      default: go <= 1'b1;
    endcase
    repeat (100) begin
      @(posedge clk_sys);
      rx_ssd_det <= 1'b0;
      rx_esd_det <= 1'b0;
      go         <= 1'b0;
      n++;
      #1;
      if ((ch == 0 && crs === 1'b1) || (ch == 1 && crs === 1'b0) ||
          (ch == 2 && line_tx_ssd === 1'b1) ||
          (ch == 3 && line_tx_esd === 1'b1)) return;
    end
    n = -1;
  endtask : run
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    results();
  end
  initial begin
    {rst_n, media_fx, rx_ssd_det, rx_esd_det, go} = 5'h00;
    sel         = 2'h0;
    len         = 8'h01;
    r           = 8'h3D;
    fail_count  = 0;
    check_count = 0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    // first eight passes walk every mode and fill code, shortest frame
    for (int i = 0; i < 32; i++) begin
      r = lfsr(r);
      @(posedge clk_sys);
      media_fx <= (i < 8) ? i[0] : r[0];
      sel      <= (i < 8) ? i[2:1] : r[2:1];
      len      <= (i < 8) ? 8'h01 : {4'h0, r[7:4]} + 8'h01;
      repeat (3) @(posedge clk_sys);
      cmp_v(8'h20 + {sel, 4'h0}, fill_bits);
      cmp_v({7'h00, sel == 2'h0}, {7'h00, fill_default});
      for (int ch = 0; ch < 4; ch++) begin
        run(ch, k);
        cmp_n(exp_lat(ch, media_fx, sel, len), k);
        // line frame flag follows each line pulse by one cycle
        if (ch >= 2) begin
          @(posedge clk_sys);
          #1;
          cmp_v({7'h00, ch == 2}, {7'h00, line_tx_active});
        end
        if (ch != 0) repeat (25) @(posedge clk_sys);
      end
    end
    cmp_v(8'h20, frames);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    #1;
    cmp_v(8'h20, fill_bits);
    results();
  end
endmodule : smlp_port_latency_tb
`default_nettype wire
